// [design/front_panel_menu.sv]
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module front_panel_menu
  import panel_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  // Clock and reset
  input logic ref_clk,
  input logic rstn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel keys, low while touched
  input logic key_left_n,
  input logic key_down_n,
  input logic key_enter_n,
  // Serial link activity pins
  input logic tx_active,
  input logic rx_active,
  // Display drive
  output logic [1:0] disp_state,
  output logic [3:0] disp_page,
  output logic [2:0] disp_item,
  output logic [1:0] disp_cursor,
  output logic [15:0] disp_digits,
  output logic [3:0] blink_mask,
  output logic backlight_on,
  output logic comm_tx_seg,
  output logic comm_rx_seg,
  // Stored setup values
  output logic [VAL_W-1:0] vt_ratio,
  output logic [VAL_W-1:0] ct_ratio,
  output logic [7:0] node_addr,
  output logic [1:0] frame_fmt,
  output logic [2:0] output_item_pick,
  output logic [6:0] lamp_timeout,
  output logic energy_wipe
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_range(input item_t it, input logic [VAL_W-1:0] v);
    case (it)
      IT_PASS: in_range = (v <= PASS_MAX);
      IT_OUT: in_range = (v <= OUT_MAX);
      IT_VT, IT_CT: in_range = (v >= RATIO_MIN) && (v <= RATIO_MAX);
      IT_NODE: in_range = (v >= NODE_MIN) && (v <= NODE_MAX);
      IT_FMT: in_range = (v <= FMT_MAX);
      IT_LAMP: in_range = (v <= LAMP_MAX);
      IT_WIPE: in_range = (v <= WIPE_MAX);
      default: in_range = 1'b0;
    endcase
  endfunction

  function automatic logic [VAL_W-1:0] bcd_to_bin(input logic [15:0] d);
    logic [VAL_W-1:0] r;
    r = VAL_W'(d[15:12]) * VAL_W'(1000);
    r = r + VAL_W'(d[11:8]) * VAL_W'(100);
    r = r + VAL_W'(d[7:4]) * VAL_W'(10);
    r = r + VAL_W'(d[3:0]);
    return r;
  endfunction

  function automatic logic [15:0] bin_to_bcd(input logic [VAL_W-1:0] v);
    logic [15:0] b;
    b = 16'h0000;
    for (int i = VAL_W - 1; i >= 0; i--) begin
      for (int k = 0; k < DIGITS; k++) begin
        if (b[k*4 +: 4] > 4'h4) begin
          b[k*4 +: 4] = b[k*4 +: 4] + 4'h3;
        end
      end
      b = {b[14:0], v[i]};
    end
    return b;
  endfunction

  function automatic logic [15:0] bump_digit(input logic [15:0] d, input logic [1:0] c);
    logic [15:0] r;
    r = d;
    if (d[c*4 +: 4] >= DIGIT_MAX) begin
      r[c*4 +: 4] = 4'h0;
    end else begin
      r[c*4 +: 4] = d[c*4 +: 4] + 4'h1;
    end
    return r;
  endfunction

  function automatic logic ofs_item(input logic [ADDR_W-1:0] a, output item_t it);
    ofs_item = 1'b1;
    case (a)
      OFS_VT: it = IT_VT;
      OFS_CT: it = IT_CT;
      OFS_NODE: it = IT_NODE;
      OFS_FMT: it = IT_FMT;
      OFS_LAMP: it = IT_LAMP;
      OFS_OUT: it = IT_OUT;
      OFS_PASS: it = IT_PASS;
      OFS_WIPE: it = IT_WIPE;
      default: begin
        it = IT_PASS;
        ofs_item = 1'b0;
      end
    endcase
  endfunction

  // ****************************************************************
  // Reset release and time base
  // ****************************************************************
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic ms_tick;
  logic sec_tick;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  tick_gen #(.DIV(CYC_PER_MS_P)) u_ms_tick (
    .clk(ref_clk),
    .rst_n(rst_n),
    .en(1'b1),
    .tick(ms_tick)
  );

  tick_gen #(.DIV(MS_PER_S)) u_sec_tick (
    .clk(ref_clk),
    .rst_n(rst_n),
    .en(ms_tick),
    .tick(sec_tick)
  );

  // ****************************************************************
  // Keys
  // ****************************************************************
  logic left_short, left_long, down_short, down_long, enter_short, enter_long;
  logic down_p, enter_p, any_key;

  key_sense #(.DEB_MS(DEBOUNCE_MS), .LONG_MS(LONG_PRESS_MS)) u_key_left (
    .clk(ref_clk), .rst_n(rst_n), .ms_tick(ms_tick), .key_n(key_left_n),
    .short_p(left_short), .long_p(left_long)
  );
  key_sense #(.DEB_MS(DEBOUNCE_MS), .LONG_MS(LONG_PRESS_MS)) u_key_down (
    .clk(ref_clk), .rst_n(rst_n), .ms_tick(ms_tick), .key_n(key_down_n),
    .short_p(down_short), .long_p(down_long)
  );
  key_sense #(.DEB_MS(DEBOUNCE_MS), .LONG_MS(LONG_PRESS_MS)) u_key_enter (
    .clk(ref_clk), .rst_n(rst_n), .ms_tick(ms_tick), .key_n(key_enter_n),
    .short_p(enter_short), .long_p(enter_long)
  );

  // Only the left key has a distinct long action; the others act once per touch.
  assign down_p = down_short | down_long;
  assign enter_p = enter_short | enter_long;
  assign any_key = left_short | left_long | down_p | enter_p;

  // ****************************************************************
  // Stored setup values and their write path
  // ****************************************************************
  logic [VAL_W-1:0] pass_r;
  logic [VAL_W-1:0] vt_r, ct_r;
  logic [7:0] node_r;
  frame_fmt_t fmt_r;
  out_pick_t out_r;
  logic [6:0] lamp_r;
  logic wipe_r;
  ui_state_t state_r;
  page_t page_r;
  item_t item_r;
  logic [1:0] cursor_r;
  logic [15:0] edit_r;
  logic [VAL_W-1:0] edit_bin;
  logic panel_ok;
  logic apb_wr;
  item_t apb_item;
  logic apb_hit;
  logic wr_en;
  item_t wr_item;
  logic [VAL_W-1:0] wr_val;
  logic pready_r, pslverr_r;

  assign edit_bin = bcd_to_bin(edit_r);
  assign panel_ok = (state_r == ST_EDIT) && enter_p && in_range(item_r, edit_bin);
  assign apb_wr = psel && penable && pready_r && pwrite && !pslverr_r;

  always_comb begin
    apb_hit = ofs_item(paddr, apb_item);
    wr_en = (apb_wr && apb_hit) || panel_ok;
    wr_item = (apb_wr && apb_hit) ? apb_item : item_r;
    wr_val = (apb_wr && apb_hit) ? pwdata[VAL_W-1:0] : edit_bin;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_r <= PASS_DEF;
      vt_r <= RATIO_DEF;
      ct_r <= RATIO_DEF;
      node_r <= NODE_DEF[7:0];
      fmt_r <= FMT_8N1;
      out_r <= OUT_U;
      lamp_r <= LAMP_DEF[6:0];
    end else if (wr_en) begin
      case (wr_item)
        IT_PASS: pass_r <= wr_val;
        IT_OUT: out_r <= out_pick_t'(wr_val[2:0]);
        IT_VT: vt_r <= wr_val;
        IT_CT: ct_r <= wr_val;
        IT_NODE: node_r <= wr_val[7:0];
        IT_FMT: fmt_r <= frame_fmt_t'(wr_val[1:0]);
        IT_LAMP: lamp_r <= wr_val[6:0];
        default: ;
      endcase
    end
  end

  // The wipe item holds no value; confirming a one fires a single pulse.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wipe_r <= 1'b0;
    end else begin
      wipe_r <= wr_en && (wr_item == IT_WIPE) && wr_val[0];
    end
  end

  function automatic logic [VAL_W-1:0] item_value(input item_t it);
    case (it)
      IT_PASS: item_value = pass_r;
      IT_OUT: item_value = VAL_W'(out_r);
      IT_VT: item_value = vt_r;
      IT_CT: item_value = ct_r;
      IT_NODE: item_value = VAL_W'(node_r);
      IT_FMT: item_value = VAL_W'(fmt_r);
      IT_LAMP: item_value = VAL_W'(lamp_r);
      default: item_value = '0;
    endcase
  endfunction

  // ****************************************************************
  // Idle time since the last key
  // ****************************************************************
  logic [SEC_W-1:0] idle_s_r;
  logic idle_out;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_s_r <= '0;
    end else if (any_key) begin
      idle_s_r <= '0;
    end else if (sec_tick && idle_s_r != '1) begin
      idle_s_r <= idle_s_r + 1'b1;
    end
  end
  assign idle_out = (idle_s_r >= SEC_W'(IDLE_RETURN_S));

  // ****************************************************************
  // Menu state machine
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_MEAS;
      page_r <= PG_VOLT;
      item_r <= IT_PASS;
      cursor_r <= 2'h0;
      edit_r <= 16'h0000;
    end else if (state_r != ST_MEAS && idle_out) begin
      state_r <= ST_MEAS;
    end else begin
      case (state_r)
        ST_MEAS: begin
          if (left_long || enter_p) begin
            state_r <= ST_PASS;
            edit_r <= 16'h0000;
            cursor_r <= 2'h0;
          end else if (left_short) begin
            page_r <= (page_r >= PG_FREQ) ? PG_VOLT : page_t'(page_r + 4'h1);
          end else if (down_p) begin
            page_r <= (page_r == PG_DIN) ? PG_VOLT : page_t'(page_r + 4'h1);
          end
        end
        ST_PASS: begin
          if (left_long) begin
            state_r <= ST_MEAS;
          end else if (enter_p) begin
            edit_r <= 16'h0000;
            cursor_r <= 2'h0;
            if (edit_bin == pass_r) begin
              state_r <= ST_MENU;
              item_r <= IT_PASS;
            end
          end else if (left_short) begin
            cursor_r <= cursor_r + 2'h1;
          end else if (down_p) begin
            edit_r <= bump_digit(edit_r, cursor_r);
          end
        end
        ST_MENU: begin
          if (left_long) begin
            state_r <= ST_MEAS;
          end else if (down_p) begin
            item_r <= item_t'(item_r + 3'h1);
          end else if (enter_p) begin
            state_r <= ST_EDIT;
            edit_r <= bin_to_bcd(item_value(item_r));
            cursor_r <= 2'h0;
          end
        end
        ST_EDIT: begin
          if (left_long) begin
            state_r <= ST_MEAS;
          end else if (enter_p) begin
            state_r <= ST_MENU;
          end else if (left_short) begin
            cursor_r <= cursor_r + 2'h1;
          end else if (down_p) begin
            edit_r <= bump_digit(edit_r, cursor_r);
          end
        end
        default: state_r <= ST_MEAS;
      endcase
    end
  end

  // ****************************************************************
  // Blink, backlight and link indicator
  // ****************************************************************
  logic [9:0] blink_ms_r;
  logic blink_phase_r;
  logic [3:0] blink_mask_r;
  logic backlight_r;
  logic [SEC_W-1:0] lamp_limit;
  logic [1:0] act_s1_r, act_s2_r;
  logic [7:0] act_hold_r [2];
  logic [1:0] seg_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_ms_r <= '0;
      blink_phase_r <= 1'b0;
      blink_mask_r <= 4'h0;
    end else begin
      if (ms_tick) begin
        if (blink_ms_r == 10'(BLINK_HALF_MS - 1)) begin
          blink_ms_r <= '0;
          blink_phase_r <= ~blink_phase_r;
        end else begin
          blink_ms_r <= blink_ms_r + 1'b1;
        end
      end
      blink_mask_r <= (state_r == ST_EDIT && blink_phase_r) ? (4'h1 << cursor_r) : 4'h0;
    end
  end

  // Timeout of zero means the lamp never goes out.
  assign lamp_limit = SEC_W'(lamp_r) * SEC_W'(LAMP_S_PER_MIN);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      backlight_r <= 1'b1;
    end else begin
      backlight_r <= (lamp_r == 7'h00) || (idle_s_r < lamp_limit);
    end
  end

  // Activity is stretched so a short frame stays visible to the eye.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_s1_r <= 2'h0;
      act_s2_r <= 2'h0;
      seg_r <= 2'h0;
      act_hold_r[0] <= '0;
      act_hold_r[1] <= '0;
    end else begin
      act_s1_r <= {rx_active, tx_active};
      act_s2_r <= act_s1_r;
      for (int i = 0; i < 2; i++) begin
        if (act_s2_r[i]) begin
          act_hold_r[i] <= 8'(COMM_HOLD_MS);
        end else if (ms_tick && act_hold_r[i] != '0) begin
          act_hold_r[i] <= act_hold_r[i] - 1'b1;
        end
        seg_r[i] <= act_s2_r[i] || (act_hold_r[i] != '0);
      end
    end
  end

  // ****************************************************************
  // APB slave, no wait states, answers in the access cycle
  // ****************************************************************
  logic [31:0] prdata_r;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    case (paddr)
      OFS_STATUS: rd_val = {19'h0, backlight_r, state_r, cursor_r, 1'b0, item_r, page_r};
      OFS_VT: rd_val = 32'(vt_r);
      OFS_CT: rd_val = 32'(ct_r);
      OFS_NODE: rd_val = 32'(node_r);
      OFS_FMT: rd_val = 32'(fmt_r);
      OFS_LAMP: rd_val = 32'(lamp_r);
      OFS_OUT: rd_val = 32'(out_r);
      OFS_PASS, OFS_WIPE: rd_val = 32'h0;
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Errors are decided in the setup cycle, so a refused write never lands.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        prdata_r <= pwrite ? 32'h0 : rd_val;
        if (pwrite) begin
          pslverr_r <= !apb_hit || !in_range(apb_item, pwdata[VAL_W-1:0]) ||
                       (pwdata[31:VAL_W] != '0);
        end else begin
          pslverr_r <= !rd_ok;
        end
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign disp_state = state_r;
  assign disp_page = page_r;
  assign disp_item = item_r;
  assign disp_cursor = cursor_r;
  assign disp_digits = edit_r;
  assign blink_mask = blink_mask_r;
  assign backlight_on = backlight_r;
  assign comm_tx_seg = seg_r[0];
  assign comm_rx_seg = seg_r[1];
  assign vt_ratio = vt_r;
  assign ct_ratio = ct_r;
  assign node_addr = node_r;
  assign frame_fmt = fmt_r;
  assign output_item_pick = out_r;
  assign lamp_timeout = lamp_r;
  assign energy_wipe = wipe_r;

endmodule

// [design/key_sense.sv]
`timescale 1ns/100ps
module key_sense #(
  parameter int DEB_MS = 20,
  parameter int LONG_MS = 2000
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  input logic ms_tick,
  // Key pin, low while touched
  input logic key_n,
  // Press events
  output logic short_p,
  output logic long_p
);
  localparam int CW = $clog2(LONG_MS + 1);
  logic [1:0] sync_r;
  logic stable_r;
  logic [CW-1:0] deb_r;
  logic [CW-1:0] hold_r;
  logic long_done_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], ~key_n};
    end
  end

  // A level change must persist for the whole debounce time to count.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_r <= 1'b0;
      deb_r <= '0;
    end else if (sync_r[1] == stable_r) begin
      deb_r <= '0;
    end else if (ms_tick) begin
      if (deb_r == CW'(DEB_MS - 1)) begin
        stable_r <= sync_r[1];
        deb_r <= '0;
      end else begin
        deb_r <= deb_r + 1'b1;
      end
    end
  end

  // A long press fires while still held; its release then gives no short press.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= '0;
      long_done_r <= 1'b0;
      short_p <= 1'b0;
      long_p <= 1'b0;
    end else begin
      short_p <= 1'b0;
      long_p <= 1'b0;
      if (stable_r) begin
        if (ms_tick && !long_done_r) begin
          if (hold_r == CW'(LONG_MS - 1)) begin
            long_p <= 1'b1;
            long_done_r <= 1'b1;
          end else begin
            hold_r <= hold_r + 1'b1;
          end
        end
      end else begin
        if ((hold_r != '0 || deb_r == '0) && !long_done_r && hold_r != '0) begin
          short_p <= 1'b1;
        end
        hold_r <= '0;
        long_done_r <= 1'b0;
      end
    end
  end
endmodule

// [design/panel_pkg.sv]
package panel_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CYC_PER_MS = (NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int DEBOUNCE_MS = 20;
  localparam int LONG_PRESS_MS = 2000;
  localparam int BLINK_HALF_MS = 500;
  localparam int COMM_HOLD_MS = 200;
  localparam int IDLE_RETURN_S = 30;
  localparam int LAMP_S_PER_MIN = 60;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int VAL_W = 14;
  localparam int SEC_W = 13;
  localparam int ADDR_W = 12;
  localparam int DIGITS = 4;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_VT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_NODE = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_FMT = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_LAMP = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_OUT = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_PASS = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_WIPE = 12'h020;

  // ****************************************************************
  // Ranges and reset values
  // ****************************************************************
  localparam logic [VAL_W-1:0] PASS_DEF = 14'h1a0a;
  localparam logic [VAL_W-1:0] PASS_MAX = 14'h270f;
  localparam logic [VAL_W-1:0] RATIO_MIN = 14'h0001;
  localparam logic [VAL_W-1:0] RATIO_MAX = 14'h270f;
  localparam logic [VAL_W-1:0] RATIO_DEF = 14'h0001;
  localparam logic [VAL_W-1:0] NODE_MIN = 14'h0001;
  localparam logic [VAL_W-1:0] NODE_MAX = 14'h00f7;
  localparam logic [VAL_W-1:0] NODE_DEF = 14'h0001;
  localparam logic [VAL_W-1:0] FMT_MAX = 14'h0002;
  localparam logic [VAL_W-1:0] LAMP_MAX = 14'h0078;
  localparam logic [VAL_W-1:0] LAMP_DEF = 14'h000a;
  localparam logic [VAL_W-1:0] OUT_MAX = 14'h0006;
  localparam logic [VAL_W-1:0] WIPE_MAX = 14'h0001;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_MEAS = 2'b00, ST_PASS = 2'b01, ST_MENU = 2'b11, ST_EDIT = 2'b10
  } ui_state_t;

  typedef enum logic [3:0] {
    PG_VOLT, PG_CURR, PG_P, PG_Q, PG_S, PG_PF, PG_FREQ, PG_EP, PG_EQ,
    PG_TEMP, PG_WORK, PG_LOAD, PG_RELAY, PG_DIN
  } page_t;

  typedef enum logic [2:0] {
    IT_PASS, IT_OUT, IT_VT, IT_CT, IT_NODE, IT_FMT, IT_LAMP, IT_WIPE
  } item_t;

  typedef enum logic [1:0] {FMT_8N1 = 2'h0, FMT_8E1 = 2'h1, FMT_8O1 = 2'h2} frame_fmt_t;

  typedef enum logic [2:0] {
    OUT_U = 3'h0, OUT_I, OUT_P, OUT_Q, OUT_S, OUT_PF, OUT_F
  } out_pick_t;

endpackage

// [design/tick_gen.sv]
`timescale 1ns/100ps
module tick_gen #(
  parameter int DIV = 100000
) (
  // Clock and reset
  input logic clk,
  input logic rst_n,
  // Count enable and output pulse
  input logic en,
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else if (en) begin
      if (cnt_r == W'(DIV - 1)) begin
        cnt_r <= '0;
        tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
        tick <= 1'b0;
      end
    end else begin
      tick <= 1'b0;
    end
  end
endmodule

// [dv/panel_operator.sv]
`timescale 1ns/100ps
module panel_operator (
  // Clock
  input logic ref_clk,
  // Key pins, low while touched
  output logic key_left_n,
  output logic key_down_n,
  output logic key_enter_n
);
  logic [2:0] keys_n = 3'h7;
  assign {key_enter_n, key_down_n, key_left_n} = keys_n;
  // The quiet gap after release must outlast the debounce, or presses merge.
  task automatic press(input int k, input int hold);
    keys_n[k] <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    keys_n[k] <= 1'b1;
    repeat (600) @(posedge ref_clk);
  endtask
endmodule

// [dv/panel_props.sv]
`timescale 1ns/100ps
module panel_props
  import panel_pkg::*;
(
  // Bus
  input logic ref_clk,
  input logic rstn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  // Panel and setup values
  input logic [1:0] disp_state,
  input logic [3:0] disp_page,
  input logic [3:0] blink_mask,
  input logic [VAL_W-1:0] vt_ratio,
  input logic [1:0] frame_fmt,
  input logic [6:0] lamp_timeout,
  input logic energy_wipe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire w = psel && penable && pready && pwrite;
  a_vt_store:
    assert property (w && paddr == OFS_VT && !pslverr |=> vt_ratio == $past(pwdata))
    else $error("vt ratio not stored");
  a_node_refuse:
    assert property (w && paddr == OFS_NODE && !(pwdata inside {[NODE_MIN:NODE_MAX]}) |-> pslverr)
    else $error("bad node accepted");
  a_fmt_store:
    assert property (w && paddr == OFS_FMT && !pslverr |=> frame_fmt == $past(pwdata))
    else $error("format not stored");
  a_lamp_keep:
    assert property (w && paddr == OFS_LAMP && pslverr |=> $stable(lamp_timeout))
    else $error("refused lamp write landed");
  a_wipe_pulse:
    assert property (w && paddr == OFS_WIPE && pwdata == 32'h1 |=> energy_wipe ##1 !energy_wipe)
    else $error("wipe pulse wrong");
  a_page_step:
    assert property ($changed(disp_page) && disp_state == 2'h0 |->
      disp_page == $past(disp_page) + 4'h1 || disp_page == 4'h0) else $error("page skipped");
  a_page_max:
    assert property (disp_page <= 4'hd) else $error("page out of range");
  a_blink_edit:
    assert property (blink_mask != 4'h0 |-> $past(disp_state) == 2'h2)
    else $error("blink outside edit");
  c_wipe: cover property (energy_wipe);
  c_edit: cover property (disp_state == 2'h2);
  c_err: cover property (pslverr);
endmodule
bind front_panel_menu panel_props u_props (.*);

// [dv/testbench.sv]
`timescale 1ns/100ps
module testbench;
  import panel_pkg::*;
  typedef struct packed {logic [11:0] a; logic [15:0] d; logic e; logic [15:0] r;} row_t;
  localparam row_t ROWS[8] = '{
    '{12'h004, 16'h270f, 1'b0, 16'h270f}, '{12'h004, 16'h0000, 1'b1, 16'h270f},
    '{12'h008, 16'h2710, 1'b1, 16'h0001}, '{12'h00c, 16'h00f8, 1'b1, 16'h0001},
    '{12'h010, 16'h0003, 1'b1, 16'h0000}, '{12'h010, 16'h0002, 1'b0, 16'h0002},
    '{12'h014, 16'h0079, 1'b1, 16'h000a}, '{12'h018, 16'h0006, 1'b0, 16'h0006}};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic tx_active = 1'b0;
  logic rx_active = 1'b0;
  logic pready, pslverr, key_left_n, key_down_n, key_enter_n, backlight_on, err;
  logic comm_tx_seg, comm_rx_seg, energy_wipe;
  logic [1:0] disp_state, disp_cursor, frame_fmt;
  logic [3:0] disp_page, blink_mask;
  logic [2:0] disp_item, output_item_pick;
  logic [15:0] disp_digits;
  logic [VAL_W-1:0] vt_ratio, ct_ratio;
  logic [7:0] node_addr;
  logic [6:0] lamp_timeout;
  logic [31:0] prdata, rd;
  int n_errors = 0;
  int cmp_count = 0;
  front_panel_menu #(.CYC_PER_MS_P(10)) DUT (.*);
  panel_operator op (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial begin
    repeat (80000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check("panel reset", {disp_state, disp_cursor, disp_item, disp_digits, blink_mask,
                          backlight_on}, 28'h0000001);
    check("ratios", {vt_ratio, ct_ratio}, {RATIO_DEF, RATIO_DEF});
    check("setup", {node_addr, frame_fmt, output_item_pick, lamp_timeout}, 20'h0100a);
    check("comm idle", {comm_tx_seg, comm_rx_seg}, 2'h0);
    foreach (ROWS[i]) begin
      apb(1'b1, ROWS[i].a, 32'(ROWS[i].d));
      check("write error", err, ROWS[i].e);
      apb(1'b0, ROWS[i].a, 32'h0);
      check("read back", rd, 32'(ROWS[i].r));
    end
    apb(1'b0, 12'h024, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b1, OFS_WIPE, 32'h1);
    check("wipe pulse", energy_wipe, 1'b1);
    $display("register tests done");
    tx_active <= 1'b1;
    rx_active <= 1'b1;
    repeat (50) @(posedge ref_clk);
    check("comm lit", {comm_tx_seg, comm_rx_seg}, 2'h3);
    tx_active <= 1'b0;
    rx_active <= 1'b0;
    repeat (2500) @(posedge ref_clk);
    check("comm dark", {comm_tx_seg, comm_rx_seg}, 2'h0);
    $display("link indicator test done");
    // A one-digit code keeps the entry walk short.
    apb(1'b1, OFS_PASS, 32'h1);
    op.press(1, 400);
    check("page down", disp_page, 4'h1);
    op.press(0, 400);
    check("page left", disp_page, 4'h2);
    repeat (12) op.press(1, 400);
    check("page wrap", disp_page, 4'h0);
    op.press(0, 21000);
    check("code page", disp_state, 2'h1);
    op.press(2, 400);
    check("wrong code", disp_state, 2'h1);
    op.press(1, 400);
    check("code digit", disp_digits, 16'h0001);
    op.press(2, 400);
    check("menu", disp_state, 2'h3);
    op.press(2, 400);
    check("edit", disp_state, 2'h2);
    check("edit digits", disp_digits, 16'h0001);
    op.press(2, 400);
    check("confirm", disp_state, 2'h3);
    repeat (2) op.press(1, 400);
    check("item", disp_item, 3'h2);
    op.press(2, 400);
    check("ratio digits", disp_digits, 16'h9999);
    op.press(1, 400);
    check("digit wrap", disp_digits, 16'h9990);
    op.press(2, 400);
    check("stored", vt_ratio, 14'h2706);
    op.press(2, 400);
    op.press(0, 21000);
    check("exit", disp_state, 2'h0);
    $display("panel key tests done");
    tally_and_finish;
  end
endmodule
